//--- verilog/adc_sequence_control.sv
// register control of the converter sequencer and input threshold
`timescale 1ns/1ps
// How it works
// (R1) reference bit picks supply or fixed range
// (R2) five-bit code sets digital input threshold
// (R3) bit 10 selects diagnostic mains rejection
// (R4) idle stops continuous, powers converter up
// (R5) busy reads one throughout power-up
// (R6) host waits for power-up before starting
// (R7) single command converts each enabled slot once
// (R8) command field keeps value; rewrite retriggers
// (R9) single from power-down powers up first
// (R10) continuous command cycles enabled slots forever
// (R11) enable set frozen during a sequence
// (R12) host goes idle before continuous to single
// (R13) power-down command stops and powers off
// (R14) host polls busy before new sequence
// (R15) bits 7:4 diagnostics, 3:0 channels
// (R16) diagnostic slot converts separately assigned node
// (R17) reserved bits ignore writes, read zero
module adc_sequence_control (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        conv_done_in,
  output logic      [15:0] reg_rdata_out,
  output logic      [4:0]  comparator_threshold_code_out,
  output logic             threshold_reference_select_out,
  output logic             diag_mains_rejection_enable_out,
  output logic             adc_power_on_out,
  output logic             adc_busy_out,
  output logic             conv_start_out,
  output logic      [2:0]  conv_slot_out
);
  typedef enum {st_off, st_powerup, st_on} power_state_t;

  seq_if sq ();

  power_state_t      state_reg;
  power_state_t      state_next;
  logic [15:0]       thresh_reg;
  logic [15:0]       thresh_next;
  logic [15:0]       conv_reg;
  logic [15:0]       conv_next;
  logic [15:0]       rdata_reg;
  logic [15:0]       rdata_next;
  logic [11:0]       timer_reg;
  logic [11:0]       timer_next;
  logic [1:0]        pend_reg;
  logic [1:0]        pend_next;
  logic              busy_reg;
  logic              busy_next;
  logic              power_reg;
  logic              power_next;
  logic              start;
  logic              stop;
  logic [1:0]        launch;
  logic              wr_thr;
  logic              wr_conv;
  logic [1:0]        cmd;

  assign wr_thr  = reg_wr_in && (reg_addr_in == adc_seq_pkg::ADDR_THRESH);
  assign wr_conv = reg_wr_in && (reg_addr_in == adc_seq_pkg::ADDR_CONV);
  assign cmd     = reg_wdata_in[adc_seq_pkg::CMD_MSB:adc_seq_pkg::CMD_LSB];

  // register file and read port
  always_comb
  begin
    thresh_next = thresh_reg;
    conv_next   = conv_reg;
    rdata_next  = rdata_reg;
    if (wr_thr)
      thresh_next = reg_wdata_in & adc_seq_pkg::THRESH_MASK; // see (R17)
    if (wr_conv)
      conv_next = reg_wdata_in & adc_seq_pkg::CONV_MASK; // see (R17) (R8)
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        adc_seq_pkg::ADDR_THRESH: rdata_next = thresh_reg;
        adc_seq_pkg::ADDR_CONV:   rdata_next = conv_reg;
        default:                  rdata_next = adc_seq_pkg::REG_RESET;
      endcase
    end
  end

  // power state and sequence launch; host keeps the waits and ordering (R6) (R12) (R14)
  always_comb
  begin
    state_next = state_reg;
    timer_next = timer_reg;
    pend_next  = pend_reg;
    start      = 1'b0;
    stop       = 1'b0;
    launch     = pend_reg;
    case (state_reg)
      st_off:
      begin
        if (wr_conv && (cmd != adc_seq_pkg::CMD_DOWN))
        begin
          state_next = st_powerup; // see (R4) (R9)
          timer_next = adc_seq_pkg::PWRUP_LOAD;
          pend_next  = cmd;
        end
      end
      st_powerup:
      begin
        if (timer_reg == adc_seq_pkg::TIMER_ZERO)
        begin
          state_next = st_on;
          pend_next  = adc_seq_pkg::CMD_IDLE;
          // queued start waits out the full power-up time
          start      = (pend_reg != adc_seq_pkg::CMD_IDLE); // see (R9)
        end
        else
          timer_next = timer_reg - 12'h001;
        if (wr_conv)
        begin
          // a later command replaces the queued one
          pend_next = cmd;
          start     = 1'b0;
          if (timer_reg == adc_seq_pkg::TIMER_ZERO)
            state_next = st_powerup;
          if (cmd == adc_seq_pkg::CMD_DOWN)
            state_next = st_off; // see (R13)
        end
      end
      st_on:
      begin
        if (wr_conv)
        begin
          launch = cmd;
          case (cmd)
            adc_seq_pkg::CMD_DOWN:
            begin
              stop       = 1'b1; // see (R13)
              state_next = st_off;
            end
            adc_seq_pkg::CMD_IDLE: stop = 1'b1; // see (R4)
            // ignored by the walker while a sequence still runs
            default:               start = 1'b1; // see (R7) (R10)
          endcase
        end
      end
      default: state_next = st_off;
    endcase
    if (state_next != st_powerup && state_reg == st_powerup && wr_conv)
      pend_next = adc_seq_pkg::CMD_IDLE;
    busy_next  = (state_next == st_powerup) || start || (sq.busy && !stop); // see (R5)
    power_next = (state_next != st_off);
  end

  assign sq.start     = start;
  assign sq.stop      = stop;
  assign sq.cont      = (launch == adc_seq_pkg::CMD_CONT); // see (R10)
  assign sq.mask      = conv_next[adc_seq_pkg::EN_MSB:adc_seq_pkg::EN_LSB]; // see (R15)
  assign sq.conv_done = conv_done_in;

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      thresh_reg <= adc_seq_pkg::REG_RESET;
      conv_reg   <= adc_seq_pkg::REG_RESET;
      rdata_reg  <= adc_seq_pkg::REG_RESET;
      state_reg  <= st_off;
      timer_reg  <= adc_seq_pkg::TIMER_ZERO;
      pend_reg   <= adc_seq_pkg::CMD_IDLE;
      busy_reg   <= 1'b0;
      power_reg  <= 1'b0;
    end
    else
    begin
      thresh_reg <= thresh_next;
      conv_reg   <= conv_next;
      rdata_reg  <= rdata_next;
      state_reg  <= state_next;
      timer_reg  <= timer_next;
      pend_reg   <= pend_next;
      busy_reg   <= busy_next;
      power_reg  <= power_next;
    end
  end

  slot_walker walker (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .sq         (sq.walker)
  );

  assign reg_rdata_out                   = rdata_reg;
  // threshold DAC reference: 0 tracks the analog supply, 1 uses the fixed range
  assign threshold_reference_select_out  = thresh_reg[adc_seq_pkg::THR_REF_BIT]; // see (R1)
  assign comparator_threshold_code_out   =
    thresh_reg[adc_seq_pkg::THR_CODE_MSB:adc_seq_pkg::THR_CODE_LSB]; // see (R2)
  // sets the diagnostic sample rate in the converter
  assign diag_mains_rejection_enable_out = conv_reg[adc_seq_pkg::REJ_BIT]; // see (R3)
  assign adc_power_on_out                = power_reg;
  assign adc_busy_out                    = busy_reg; // see (R5)
  assign conv_start_out                  = sq.conv_start;
  // slots 4..7 convert the node picked by the diagnostic source select register
  assign conv_slot_out                   = sq.slot; // see (R16) (R15)

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  property p_thr_code;
    wr_thr |=> comparator_threshold_code_out
      == $past(reg_wdata_in[adc_seq_pkg::THR_CODE_MSB:adc_seq_pkg::THR_CODE_LSB]);
  endproperty
  a_thr_code: assert property (p_thr_code) // see (R2)
    else $error("threshold code not taken from write");

  property p_thr_ref;
    wr_thr |=> threshold_reference_select_out == $past(reg_wdata_in[adc_seq_pkg::THR_REF_BIT]);
  endproperty
  a_thr_ref: assert property (p_thr_ref) // see (R1)
    else $error("reference select not taken from write");

  property p_rej;
    wr_conv |=> diag_mains_rejection_enable_out == $past(reg_wdata_in[adc_seq_pkg::REJ_BIT]);
  endproperty
  a_rej: assert property (p_rej) // see (R3)
    else $error("rejection select not taken from write");

  property p_reserved;
    reg_rd_in |=> ((reg_rdata_out & ~(($past(reg_addr_in) == adc_seq_pkg::ADDR_THRESH)
      ? adc_seq_pkg::THRESH_MASK : adc_seq_pkg::CONV_MASK)) == 16'h0000);
  endproperty
  a_reserved: assert property (p_reserved) // see (R17)
    else $error("reserved bits read non-zero");

  property p_cmd_hold;
    !wr_conv |=> $stable(conv_reg);
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) // see (R8)
    else $error("control register changed without a write");

  property p_pwrup_busy;
    // same cycle: a power-down write may legally cut the power-up short
    (state_reg == st_powerup) |-> adc_busy_out;
  endproperty
  a_pwrup_busy: assert property (p_pwrup_busy) // see (R5)
    else $error("busy low during power-up");

  property p_idle_wakes;
    (state_reg == st_off && wr_conv && cmd == adc_seq_pkg::CMD_IDLE) |=>
      (state_reg == st_powerup && timer_reg == adc_seq_pkg::PWRUP_LOAD && adc_busy_out);
  endproperty
  a_idle_wakes: assert property (p_idle_wakes) // see (R4)
    else $error("idle command did not start power-up");

  property p_single_wakes;
    (state_reg == st_off && wr_conv && cmd == adc_seq_pkg::CMD_SINGLE) |=>
      (state_reg == st_powerup && pend_reg == adc_seq_pkg::CMD_SINGLE && !sq.busy);
  endproperty
  a_single_wakes: assert property (p_single_wakes) // see (R9)
    else $error("single command from power-down mishandled");

  property p_down;
    (wr_conv && cmd == adc_seq_pkg::CMD_DOWN) |=> (state_reg == st_off && !adc_power_on_out
      && !sq.busy);
  endproperty
  a_down: assert property (p_down) // see (R13)
    else $error("power-down command did not stop and power off");
endmodule

//--- verilog/adc_seq_pkg.sv
// constants for the converter sequence control block
package adc_seq_pkg;
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 16;
  localparam int          SLOT_W       = 3;
  localparam int          NSLOT        = 8;
  localparam int          TIMER_W      = 12;
  localparam logic [7:0]  ADDR_THRESH  = 8'h22;
  localparam logic [7:0]  ADDR_CONV    = 8'h23;
  localparam logic [15:0] REG_RESET    = 16'h0000;
  localparam logic [15:0] THRESH_MASK  = 16'h003F;
  localparam logic [15:0] CONV_MASK    = 16'h07FF;
  localparam int          THR_REF_BIT  = 0;
  localparam int          THR_CODE_LSB = 1;
  localparam int          THR_CODE_MSB = 5;
  localparam int          EN_LSB       = 0;
  localparam int          EN_MSB       = 7;
  localparam int          CMD_LSB      = 8;
  localparam int          CMD_MSB      = 9;
  localparam int          REJ_BIT      = 10;
  localparam logic [1:0]  CMD_IDLE     = 2'h0;
  localparam logic [1:0]  CMD_SINGLE   = 2'h1;
  localparam logic [1:0]  CMD_CONT     = 2'h2;
  localparam logic [1:0]  CMD_DOWN     = 2'h3;
  localparam logic [2:0]  SLOT_LAST    = 3'h7;
  localparam logic [2:0]  SLOT_FIRST   = 3'h0;
  localparam longint      CLK_HZ       = 25000000;
  localparam longint      PWRUP_US     = 100;
  localparam int          PWRUP_CYC    = int'((PWRUP_US * CLK_HZ + 64'd999999) / 64'd1000000);
  localparam logic [TIMER_W-1:0] PWRUP_LOAD = TIMER_W'(PWRUP_CYC - 1);
  localparam logic [TIMER_W-1:0] TIMER_ZERO = 12'h000;
endpackage

//--- verilog/seq_if.sv
// link between command control and slot walker
`timescale 1ns/1ps
interface seq_if;
  logic       start;
  logic       cont;
  logic       stop;
  logic [7:0] mask;
  logic       conv_done;
  logic       busy;
  logic       conv_start;
  logic [2:0] slot;
  modport ctrl (output start, cont, stop, mask, conv_done, input busy, conv_start, slot);
  modport walker (input start, cont, stop, mask, conv_done, output busy, conv_start, slot);
endinterface

//--- verilog/slot_walker.sv
// steps through enabled conversion slots
`timescale 1ns/1ps
module slot_walker (
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  seq_if.walker     sq
);
  typedef enum {w_idle, w_issue, w_wait} walk_state_t;

  walk_state_t state_reg;
  walk_state_t state_next;
  logic [7:0]  mask_reg;
  logic [7:0]  mask_next;
  logic        cont_reg;
  logic        cont_next;
  logic [2:0]  slot_reg;
  logic [2:0]  slot_next;
  logic        start_reg;
  logic        start_next;
  logic        busy_reg;
  logic        busy_next;
  logic [3:0]  found;

  // lowest enabled slot at or above from; bit 3 set when one exists
  function automatic logic [3:0] find_slot(input logic [7:0] m, input logic [2:0] from);
    logic [3:0] r;
    r = 4'h0;
    for (int i = adc_seq_pkg::NSLOT - 1; i >= 0; i--)
    begin
      if (m[i] && (3'(i) >= from))
        r = {1'b1, 3'(i)};
    end
    return r;
  endfunction

  always_comb
  begin
    found      = 4'h0;
    state_next = state_reg;
    mask_next  = mask_reg;
    cont_next  = cont_reg;
    slot_next  = slot_reg;
    start_next = 1'b0;
    if (sq.stop)
      state_next = w_idle;
    else
    begin
      case (state_reg)
        w_idle:
        begin
          if (sq.start)
          begin
            mask_next = sq.mask; // see (R11)
            cont_next = sq.cont;
            found     = find_slot(sq.mask, adc_seq_pkg::SLOT_FIRST); // see (R15)
            if (found[3])
            begin
              slot_next  = found[2:0];
              state_next = w_issue;
            end
          end
        end
        w_issue:
        begin
          start_next = 1'b1;
          state_next = w_wait;
        end
        w_wait:
        begin
          if (sq.conv_done)
          begin
            if (slot_reg != adc_seq_pkg::SLOT_LAST)
              found = find_slot(mask_reg, slot_reg + 3'h1); // see (R7)
            if (!found[3] && cont_reg)
              found = find_slot(mask_reg, adc_seq_pkg::SLOT_FIRST); // see (R10)
            if (found[3])
            begin
              slot_next  = found[2:0];
              state_next = w_issue;
            end
            else
              state_next = w_idle;
          end
        end
        default: state_next = w_idle;
      endcase
    end
    busy_next = (state_next != w_idle);
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_reg <= w_idle;
      mask_reg  <= 8'h00;
      cont_reg  <= 1'b0;
      slot_reg  <= 3'h0;
      start_reg <= 1'b0;
      busy_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      mask_reg  <= mask_next;
      cont_reg  <= cont_next;
      slot_reg  <= slot_next;
      start_reg <= start_next;
      busy_reg  <= busy_next;
    end
  end

  assign sq.busy       = busy_reg;
  assign sq.conv_start = start_reg;
  assign sq.slot       = slot_reg;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  property p_slot_enabled;
    start_reg |-> mask_reg[slot_reg];
  endproperty
  a_slot_enabled: assert property (p_slot_enabled) // see (R7)
    else $error("conversion issued on a disabled slot");

  property p_mask_frozen;
    (state_reg != w_idle) |=> $stable(mask_reg);
  endproperty
  a_mask_frozen: assert property (p_mask_frozen) // see (R11)
    else $error("enable set changed during a sequence");

  property p_cont_wraps;
    // a stop taken in the issue cycle legally cancels that start
    (state_reg == w_wait && sq.conv_done && cont_reg && !sq.stop) |=> (state_reg == w_issue)
      ##1 (start_reg || $past(sq.stop));
  endproperty
  a_cont_wraps: assert property (p_cont_wraps) // see (R10)
    else $error("continuous sequence did not go on");

  property p_single_ends;
    (state_reg == w_wait && sq.conv_done && !cont_reg && !sq.stop
      && ((mask_reg >> slot_reg) == 8'h01)) |=> (state_reg == w_idle) ##1 !busy_reg;
  endproperty
  a_single_ends: assert property (p_single_ends) // see (R7)
    else $error("single sequence did not stop after last slot");
endmodule

//--- bench/conv_model.sv
// converter stand-in that answers each conversion start with a done pulse
`timescale 1ns/1ps
module conv_model (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  input  wire logic       conv_start_in,
  input  wire logic [3:0] delay_in,
  output logic            conv_done_out
);
  logic [3:0] wait_reg;
  logic       active_reg;
  // done never lands in the start cycle; a real conversion takes time
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wait_reg      <= 4'h0;
      active_reg    <= 1'b0;
      conv_done_out <= 1'b0;
    end
    else
    begin
      conv_done_out <= 1'b0;
      if (conv_start_in)
      begin
        active_reg <= 1'b1;
        wait_reg   <= delay_in;
      end
      else if (active_reg && wait_reg == 4'h0)
      begin
        conv_done_out <= 1'b1;
        active_reg    <= 1'b0;
      end
      else if (active_reg)
        wait_reg <= wait_reg - 4'h1;
    end
  end
endmodule

//--- bench/testbench.sv
// host-side stimulus and checks for the sequence control block
`timescale 1ns/1ps
module testbench;
  logic        ref_clk_in   = 1'b0;
  logic        rst_in       = 1'b1;
  logic        reg_wr_in    = 1'b0;
  logic        reg_rd_in    = 1'b0;
  logic [7:0]  reg_addr_in  = 8'h00;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic [3:0]  delay        = 4'h0;
  logic        conv_done_in;
  logic [15:0] reg_rdata_out;
  logic [4:0]  code;
  logic        ref_sel;
  logic        rej;
  logic        pwr;
  logic        busy;
  logic        cstart;
  logic [2:0]  slot;
  logic [2:0]  q[$];
  int          n_mismatch   = 0;
  int          total_checks = 0;
  int          cycles       = 0;

  adc_sequence_control u_dut (
    .ref_clk_in                      (ref_clk_in),
    .rst_in                          (rst_in),
    .reg_wr_in                       (reg_wr_in),
    .reg_rd_in                       (reg_rd_in),
    .reg_addr_in                     (reg_addr_in),
    .reg_wdata_in                    (reg_wdata_in),
    .conv_done_in                    (conv_done_in),
    .reg_rdata_out                   (reg_rdata_out),
    .comparator_threshold_code_out   (code),
    .threshold_reference_select_out  (ref_sel),
    .diag_mains_rejection_enable_out (rej),
    .adc_power_on_out                (pwr),
    .adc_busy_out                    (busy),
    .conv_start_out                  (cstart),
    .conv_slot_out                   (slot)
  );

  conv_model u_conv (
    .ref_clk_in    (ref_clk_in),
    .rst_in        (rst_in),
    .conv_start_in (cstart),
    .delay_in      (delay),
    .conv_done_out (conv_done_in)
  );

  always #20 ref_clk_in = ~ref_clk_in;

  always @(posedge ref_clk_in)
  begin
    if (cstart === 1'b1)
      q.push_back(slot);
  end

  task automatic give_verdict();
    if (n_mismatch == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // three power-ups dominate the run length
  always @(posedge ref_clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick();
    @(posedge ref_clk_in);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] w);
    @(posedge ref_clk_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= w;
    delay        <= 4'($urandom_range(0, 9));
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    d = reg_rdata_out;
  endtask

  // host polls busy until the running sequence has ended
  task automatic wait_idle();
    int i;
    i = 0;
    repeat (2) tick();
    while (busy !== 1'b0 && i < 4000)
    begin
      tick();
      i++;
    end
    chk(16'(busy), 16'h0000);
  endtask

  task automatic wait_q(input int k);
    int i;
    i = 0;
    while (q.size() < k && i < 4000)
    begin
      tick();
      i++;
    end
  endtask

  function automatic int pop_count(input logic [7:0] m);
    int n;
    n = 0;
    for (int s = 0; s < 8; s++)
      n += int'(m[s]);
    return n;
  endfunction

  // expected order: ascending slot number over the enabled bits
  task automatic chk_slots(input logic [7:0] m, input int rounds);
    for (int r = 0; r < rounds; r++)
      for (int s = 0; s < 8; s++)
        if (m[s])
        begin
          if (q.size() == 0)
            chk(16'hFFFF, 16'(s));
          else
            chk(16'(q.pop_front()), 16'(s));
        end
  endtask

  logic [15:0] w;
  logic [15:0] d;
  logic [7:0]  m;
  logic [7:0]  tbl[7] = '{8'h01, 8'h80, 8'hFF, 8'h00, 8'h5A, 8'h00, 8'h00};
  int          n;

  initial
  begin
    void'($urandom(73131));
    repeat (20) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rd(adc_seq_pkg::ADDR_THRESH, d);
    chk(d, adc_seq_pkg::REG_RESET);
    rd(adc_seq_pkg::ADDR_CONV, d);
    chk(d, adc_seq_pkg::REG_RESET);
    chk(16'({pwr, busy}), 16'h0000);
    for (int i = 0; i < 8; i++)
    begin
      w = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($urandom);
      wr(adc_seq_pkg::ADDR_THRESH, w);
      #1;
      chk(16'(code), 16'(w[5:1]));
      chk(16'(ref_sel), 16'(w[0]));
      rd(adc_seq_pkg::ADDR_THRESH, d);
      chk(d, w & adc_seq_pkg::THRESH_MASK);
    end
    // command kept at power-down so random enables start nothing
    for (int i = 0; i < 4; i++)
    begin
      w = 16'($urandom) | 16'h0300;
      wr(adc_seq_pkg::ADDR_CONV, w);
      tick();
      chk(16'(rej), 16'(w[10]));
      chk(16'(pwr), 16'h0000);
      rd(adc_seq_pkg::ADDR_CONV, d);
      chk(d, w & adc_seq_pkg::CONV_MASK);
    end
    wr(8'($urandom_range(36, 255)), 16'hFFFF);
    rd(8'($urandom_range(36, 255)), d);
    chk(d, 16'h0000);
    wr(adc_seq_pkg::ADDR_CONV, 16'h0000);
    tick();
    chk(16'({pwr, busy}), 16'h0003);
    n = 0;
    while (busy !== 1'b0 && n < 3000)
    begin
      tick();
      n++;
    end
    // first power-up cycle already spent in the tick above
    chk(16'(n + 1), 16'(adc_seq_pkg::PWRUP_CYC));
    chk(16'(pwr), 16'h0001);
    for (int i = 0; i < 7; i++)
    begin
      m = (i > 4) ? 8'($urandom) : tbl[i];
      wr(adc_seq_pkg::ADDR_CONV, {8'h01, m});
      wait_idle();
      chk_slots(m, 1);
      chk(16'(q.size()), 16'h0000);
      rd(adc_seq_pkg::ADDR_CONV, d);
      chk(d, {8'h01, m});
    end
    m = 8'h96;
    wr(adc_seq_pkg::ADDR_CONV, {8'h02, m});
    wait_q(2 * pop_count(m));
    // enable change mid-run must not reach the running walk
    wr(adc_seq_pkg::ADDR_CONV, 16'h020F);
    wait_q(3 * pop_count(m));
    wr(adc_seq_pkg::ADDR_CONV, 16'h0000);
    wait_idle();
    chk(16'(pwr), 16'h0001);
    chk_slots(m, 3);
    q.delete();
    wr(adc_seq_pkg::ADDR_CONV, 16'h02FF);
    wait_q(3);
    wr(adc_seq_pkg::ADDR_CONV, 16'h0300);
    tick();
    tick();
    chk(16'({pwr, busy}), 16'h0000);
    q.delete();
    repeat (20) tick();
    chk(16'(q.size()), 16'h0000);
    wr(adc_seq_pkg::ADDR_CONV, 16'h0111);
    n = 0;
    while (q.size() == 0 && n < 4000)
    begin
      tick();
      n++;
    end
    chk(16'(n >= 2500 && n < 2600), 16'h0001);
    wait_idle();
    chk_slots(8'h11, 1);
    chk(16'(q.size()), 16'h0000);
    // power-down written while a queued continuous start powers up
    wr(adc_seq_pkg::ADDR_CONV, 16'h0300);
    wr(adc_seq_pkg::ADDR_CONV, 16'h0212);
    tick();
    chk(16'({pwr, busy}), 16'h0003);
    wr(adc_seq_pkg::ADDR_CONV, 16'h0300);
    tick();
    chk(16'({pwr, busy}), 16'h0000);
    repeat (20) tick();
    chk(16'(q.size()), 16'h0000);
    // continuous from power-down, then idle before a single
    wr(adc_seq_pkg::ADDR_CONV, 16'h0212);
    wait_q(4);
    chk_slots(8'h12, 2);
    wr(adc_seq_pkg::ADDR_CONV, 16'h0000);
    wait_idle();
    q.delete();
    wr(adc_seq_pkg::ADDR_CONV, 16'h0112);
    wait_idle();
    chk_slots(8'h12, 1);
    chk(16'(q.size()), 16'h0000);
    give_verdict();
  end
endmodule
